// ===== core/power_reset_pkg.sv
// Package with mode encodings, pin-function selects, reset values and timing counts.
// Assumes a single 100 MHz clock domain in the sequencer that imports it.
package power_reset_pkg;
  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS      = 10000;
  // Reset hold time in microseconds, and the derived cycle count (least time, rounded up)
  localparam int unsigned RESET_TIME_US      = 100;
  localparam int unsigned RESET_CYCLES       = (RESET_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Interrupt high pulse time in microseconds, and its cycle count
  localparam int unsigned IRQ_PULSE_US       = 1;
  localparam int unsigned IRQ_PULSE_CYCLES   = (IRQ_PULSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Number of interrupt status registers and their reset value
  localparam int unsigned IRQ_STATUS_COUNT   = 4;
  localparam logic [7:0]  IRQ_STATUS_RESET   = 8'hFF;
  // Crystal trim register width, each bit one binary-weighted step of 1 pF
  localparam int unsigned TRIM_WIDTH         = 5;
  localparam logic [4:0]  TRIM_RESET         = 5'h00;
  // Operating mode requests from the master control unit
  localparam logic [2:0]  MODE_DEEP_SLEEP    = 3'h0;
  localparam logic [2:0]  MODE_SLEEP         = 3'h1;
  localparam logic [2:0]  MODE_SLEEP_ADC     = 3'h2;
  localparam logic [2:0]  MODE_TX_IDLE       = 3'h3;
  localparam logic [2:0]  MODE_TX_READY      = 3'h4;
  localparam logic [2:0]  MODE_TRANSMIT      = 3'h5;
  localparam logic [2:0]  MODE_RECEIVE       = 3'h6;
  // Block enable vector bit positions
  localparam int unsigned EN_DIG_VREG        = 0;
  localparam int unsigned EN_ANA_VREG        = 1;
  localparam int unsigned EN_XTAL            = 2;
  localparam int unsigned EN_CFG_REGS        = 3;
  localparam int unsigned EN_SPI             = 4;
  localparam int unsigned EN_PLL             = 5;
  localparam int unsigned EN_PA              = 6;
  localparam int unsigned EN_RX              = 7;
  localparam int unsigned EN_WIDTH           = 8;
  // Enable vectors per mode
  localparam logic [7:0]  ENABLES_OFF        = 8'h00;
  localparam logic [7:0]  ENABLES_DEEP_SLEEP = 8'h09;
  localparam logic [7:0]  ENABLES_SLEEP      = 8'h1D;
  localparam logic [7:0]  ENABLES_SLEEP_ADC  = 8'h1F;
  localparam logic [7:0]  ENABLES_TX_IDLE    = 8'h1F;
  localparam logic [7:0]  ENABLES_TX_READY   = 8'h3F;
  localparam logic [7:0]  ENABLES_TRANSMIT   = 8'h7F;
  localparam logic [7:0]  ENABLES_RECEIVE    = 8'hBF;
  // Port pin function selects
  localparam logic [3:0]  PIN_TRISTATE       = 4'h0;
  localparam logic [3:0]  PIN_CLK_OUT        = 4'h1;
  localparam logic [3:0]  PIN_RX_ACTIVE      = 4'h2;
  localparam logic [3:0]  PIN_INTERRUPT      = 4'h3;
  localparam logic [3:0]  PIN_ANT_SWITCH     = 4'h4;
  localparam logic [3:0]  PIN_DATA           = 4'h5;
  localparam logic [3:0]  PIN_MATCHED_DATA   = 4'h6;
  localparam logic [3:0]  PIN_CHIP_DATA      = 4'h7;
  localparam logic [3:0]  PIN_CHIP_STROBE    = 4'h8;
  localparam logic [3:0]  PIN_RECV_DATA      = 4'h9;
  localparam logic [3:0]  PIN_RECV_STROBE    = 4'hA;
  localparam logic [3:0]  PIN_XMIT_STROBE    = 4'hB;
  localparam int unsigned PIN_COUNT          = 4;
  localparam int unsigned PIN_RF             = 3;
endpackage

// ===== core/pin_source_if.sv
// Interface carrying the internal signal sources that the port pin muxes choose from.
// Assumes all members are driven synchronously to mclk by the sequencer.
`timescale 1ns/1ps
interface pin_source_if;
  logic clk_out;      // Divided reference clock
  logic rx_active;    // Receiver-active indicator, polarity already applied
  logic irq_n;        // Interrupt level, active low
  logic ant_switch;   // Antenna switch control
  logic data;         // Demodulated data
  logic matched_data; // Matched filter data
  logic chip_data;    // Recovered chip data
  logic chip_strobe;  // Chip strobe
  logic recv_data;    // Recovered receive data
  logic recv_strobe;  // Recovered receive clock
  logic xmit_strobe;  // Transmit strobe
  modport source (output clk_out, rx_active, irq_n, ant_switch, data, matched_data,
                  chip_data, chip_strobe, recv_data, recv_strobe, xmit_strobe);
  modport sink   (input  clk_out, rx_active, irq_n, ant_switch, data, matched_data,
                  chip_data, chip_strobe, recv_data, recv_strobe, xmit_strobe);
endinterface

// ===== core/port_pin_mux.sv
// Registered function selector for the port pins, one mux per pin.
// Assumes selects come from configuration bits that are stable between writes.
`timescale 1ns/1ps
module port_pin_mux
  import power_reset_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  pin_source_if.sink            src,
  input  wire logic [PINS*4-1:0] pin_sel,
  input  wire logic [PINS*4-1:0] pin_sel_reset,
  output logic      [PINS-1:0]   pin_out,
  output logic      [PINS-1:0]   pin_oe_n
);
  initial begin
    if (PINS < 1 || PINS > 8) begin
      $error("port_pin_mux: PINS out of range");
    end
  end

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      logic [3:0] sel;    // Effective select for this pin
      logic       value;  // Selected source value
      assign sel = pin_sel[g*4 +: 4];
      // Pick the source for this pin
      always_comb begin
        value = 1'b0;
        case (sel)
          PIN_CLK_OUT:      value = src.clk_out;
          PIN_RX_ACTIVE:    value = src.rx_active;
          PIN_INTERRUPT:    value = src.irq_n;
          PIN_ANT_SWITCH:   value = src.ant_switch;
          PIN_DATA:         value = src.data;
          PIN_MATCHED_DATA: value = src.matched_data;
          PIN_CHIP_DATA:    value = src.chip_data;
          PIN_CHIP_STROBE:  value = src.chip_strobe;
          PIN_RECV_DATA:    value = src.recv_data;
          PIN_RECV_STROBE:  value = src.recv_strobe;
          PIN_XMIT_STROBE:  value = src.xmit_strobe;
          default:          value = 1'b0;
        endcase
      end
      // Register the pin; tristate releases the drive (enable high)
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          pin_out[g]  <= 1'b0;
          pin_oe_n[g] <= (pin_sel_reset[g*4 +: 4] == PIN_TRISTATE);
        end else begin
          pin_out[g]  <= value;
          pin_oe_n[g] <= (sel == PIN_TRISTATE);
        end
      end
    end
  endgenerate
endmodule

// ===== core/transceiver_power_reset_control.sv
// Power mode and reset sequencer with interrupt line, block enables and port pins.
// Assumes power_on and the brownout comparators are already synchronous to mclk.
//
// Overview of operation
// - Power-on low holds power down, all off
// - Power-on rise enables digital regulators, starts reset
// - Brownout on digital supply starts a reset
// - Interrupt held low between brownout and functional
// - Recovery pulses interrupt high, then holds reset
// - Reset exit loads status 0xFF, interrupt low
// - After reset enter sleep, accept commands
// - First status read releases interrupt high
// - Three saving, three transmit, one receive mode
// - Deep sleep keeps digital regulator and registers
// - Transmit idle, ready adds PLL, transmit PA
// - Receive enables all but power amplifier
// - Analog regulator on in sleep ADC, transmit and receive modes
// - Receiver-active indicator routable, polarity configurable
// - RF pin function selectable, defaults tristate
// - Trim write connects selected capacitors immediately
// - Sleep disconnects trim unless high precision
// - Crystal start-up low-power or high-precision selectable
// - Transmit data from FIFO or input pin
// - Receive data and clock on pins
`timescale 1ns/1ps
module transceiver_power_reset_control
  import power_reset_pkg::*;
#(
  parameter int unsigned RESET_HOLD  = RESET_CYCLES,
  parameter int unsigned PULSE_HOLD  = IRQ_PULSE_CYCLES,
  parameter int unsigned TRIM_BITS   = TRIM_WIDTH,
  parameter int unsigned STATUS_REGS = IRQ_STATUS_COUNT
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   power_on,
  input  wire logic                   brownout,
  input  wire logic                   below_functional,
  input  wire logic [2:0]             mode_req,
  input  wire logic                   status_read,
  input  wire logic [1:0]             status_read_idx,
  input  wire logic [STATUS_REGS-1:0] irq_event,
  input  wire logic                   trim_write,
  input  wire logic [TRIM_BITS-1:0]   trim_wdata,
  input  wire logic                   sleep_high_precision_sel,
  input  wire logic                   xtal_startup_hp,
  input  wire logic                   rx_active_high,
  input  wire logic [15:0]            port_pin_config_two,
  input  wire logic                   tx_from_pin,
  input  wire logic                   tx_fifo_bit,
  input  wire logic                   tx_pin_data,
  input  wire logic                   clk_ref,
  input  wire logic                   rx_data,
  input  wire logic                   rx_clock,
  input  wire logic                   ant_switch,
  input  wire logic                   matched_data,
  input  wire logic                   chip_data,
  input  wire logic                   chip_strobe,
  input  wire logic                   xmit_strobe,
  output logic                        interrupt_out_n,
  output logic                        in_reset,
  output logic                        spi_ready,
  output logic [EN_WIDTH-1:0]         block_enable,
  output logic [TRIM_BITS-1:0]        trim_caps,
  output logic                        xtal_high_precision,
  output logic [7:0]                  status_value,
  output logic                        tx_data,
  output logic                        rx_data_pin,
  output logic                        rx_clock_pin,
  output logic [PIN_COUNT-1:0]        port_pin,
  output logic [PIN_COUNT-1:0]        port_pin_oe_n
);
  initial begin
    if (RESET_HOLD < 1 || PULSE_HOLD < 1 || STATUS_REGS != 4 || TRIM_BITS > 8 || TRIM_BITS < 1) begin
      $error("transceiver_power_reset_control: unsupported parameter values");
    end
  end

  // Sequencer states
  typedef enum logic [2:0] {
    ST_POWER_DOWN,
    ST_BROWNOUT,
    ST_PULSE,
    ST_RESET_HOLD,
    ST_RUN
  } seq_state_t;

  seq_state_t                 state;         // Sequencer state
  logic                       power_on_q;    // Previous power-on level for edge detect
  logic [31:0]                hold_count;    // Reset and pulse timer
  logic                       irq_released;  // First status read seen since reset
  logic [7:0]                 status [STATUS_REGS]; // Interrupt status registers
  logic [TRIM_BITS-1:0]       trim_reg;      // Stored crystal trim value
  logic [2:0]                 mode;          // Accepted operating mode
  logic [EN_WIDTH-1:0]        next_enable;   // Decoded enables for the current mode
  logic                       rx_running;    // Receiver active this cycle
  logic [PIN_COUNT*4-1:0]     pin_sel;       // Pin function selects
  logic [PIN_COUNT*4-1:0]     pin_sel_reset; // Pin selects applied during reset
  logic                       next_irq_n;    // Interrupt level before the pin flop
  logic                       in_sleep;      // Sleep or sleep ADC mode active, not deep sleep

  pin_source_if pins ();

  // Power-on edge tracking
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      power_on_q <= 1'b0;
    end else begin
      power_on_q <= power_on;
    end
  end

  // Main sequencer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state      <= ST_POWER_DOWN;
      hold_count <= 32'h0000_0000;
    end else if (!power_on) begin
      state      <= ST_POWER_DOWN;
      hold_count <= 32'h0000_0000;
    end else begin
      case (state)
        ST_POWER_DOWN: begin
          if (!power_on_q) begin
            state      <= ST_RESET_HOLD;
            hold_count <= 32'h0000_0000;
          end
        end
        ST_BROWNOUT: begin
          // Wait for the supply to come back above threshold
          if (!brownout) begin
            state      <= ST_PULSE;
            hold_count <= 32'h0000_0000;
          end
        end
        ST_PULSE: begin
          if (brownout) begin
            state <= ST_BROWNOUT;
          end else if (hold_count >= PULSE_HOLD - 1) begin
            state      <= ST_RESET_HOLD;
            hold_count <= 32'h0000_0000;
          end else begin
            hold_count <= hold_count + 32'h0000_0001;
          end
        end
        ST_RESET_HOLD: begin
          if (brownout) begin
            state <= ST_BROWNOUT;
          end else if (hold_count >= RESET_HOLD - 1) begin
            state      <= ST_RUN;
            hold_count <= 32'h0000_0000;
          end else begin
            hold_count <= hold_count + 32'h0000_0001;
          end
        end
        ST_RUN: begin
          if (brownout) begin
            state <= ST_BROWNOUT;
          end
        end
        default: begin
          state <= ST_POWER_DOWN;
        end
      endcase
    end
  end

  // Interrupt status registers: 0xFF on reset exit, an event sets bit 0, read clears
  generate
    for (genvar r = 0; r < STATUS_REGS; r++) begin : g_status
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          status[r] <= IRQ_STATUS_RESET;
        end else if (state != ST_RUN) begin
          status[r] <= IRQ_STATUS_RESET;
        end else if (irq_event[r]) begin
          status[r] <= 8'h01 | ((status_read && status_read_idx == 2'(r)) ? 8'h00 : status[r]);
        end else if (status_read && status_read_idx == 2'(r)) begin
          status[r] <= 8'h00;
        end
      end
    end
  endgenerate

  // Release of the interrupt line on the first status read
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_released <= 1'b0;
    end else if (state != ST_RUN) begin
      irq_released <= 1'b0;
    end else if (status_read) begin
      irq_released <= 1'b1;
    end
  end

  // Interrupt level: low in brownout unless below functional, and after reset, high pulse on recovery
  always_comb begin
    next_irq_n = 1'b1;
    case (state)
      ST_POWER_DOWN: next_irq_n = 1'b1;
      ST_BROWNOUT:   next_irq_n = below_functional;
      ST_PULSE:      next_irq_n = 1'b1;
      ST_RESET_HOLD: next_irq_n = 1'b0;
      ST_RUN:        next_irq_n = irq_released;
      default:       next_irq_n = 1'b1;
    endcase
  end

  // Interrupt pin flop; host waits for the low level before SPI traffic
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= next_irq_n;
    end
  end

  // Mode register, reset to sleep whenever the sequencer is not running
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode <= MODE_SLEEP;
    end else if (state != ST_RUN) begin
      mode <= MODE_SLEEP;
    end else if (mode_req <= MODE_RECEIVE) begin
      mode <= mode_req;
    end
  end

  // Block enables per mode
  always_comb begin
    next_enable = ENABLES_OFF;
    if (state == ST_POWER_DOWN) begin
      next_enable = ENABLES_OFF;
    end else if (state != ST_RUN) begin
      next_enable = ENABLES_DEEP_SLEEP;
    end else begin
      case (mode)
        MODE_DEEP_SLEEP: next_enable = ENABLES_DEEP_SLEEP;
        MODE_SLEEP:      next_enable = ENABLES_SLEEP;
        MODE_SLEEP_ADC:  next_enable = ENABLES_SLEEP_ADC;
        MODE_TX_IDLE:    next_enable = ENABLES_TX_IDLE;
        MODE_TX_READY:   next_enable = ENABLES_TX_READY;
        MODE_TRANSMIT:   next_enable = ENABLES_TRANSMIT;
        MODE_RECEIVE:    next_enable = ENABLES_RECEIVE;
        default:         next_enable = ENABLES_SLEEP;
      endcase
    end
  end

  // Registered enables; analog regulator on in sleep ADC and all transmit and receive modes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      block_enable <= ENABLES_OFF;
    end else begin
      block_enable <= next_enable;
    end
  end

  assign rx_running = next_enable[EN_RX];
  assign in_sleep   = (state == ST_RUN) && (mode == MODE_SLEEP || mode == MODE_SLEEP_ADC);

  // Crystal trim storage, loaded on every write in the run state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trim_reg <= TRIM_BITS'(TRIM_RESET);
    end else if (state != ST_RUN) begin
      trim_reg <= TRIM_BITS'(TRIM_RESET);
    end else if (trim_write) begin
      trim_reg <= trim_wdata;
    end
  end

  // Trim capacitor connection; sleep drops them unless high precision is kept
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trim_caps           <= '0;
      xtal_high_precision <= 1'b0;
    end else if (!next_enable[EN_XTAL]) begin
      trim_caps           <= '0;
      xtal_high_precision <= 1'b0;
    end else if (in_sleep && !sleep_high_precision_sel) begin
      trim_caps           <= '0;
      xtal_high_precision <= 1'b0;
    end else begin
      trim_caps           <= trim_write ? trim_wdata : trim_reg;
      xtal_high_precision <= in_sleep ? 1'b1 : xtal_startup_hp;
    end
  end

  // Status readback, reset line and SPI availability
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      in_reset     <= 1'b1;
      spi_ready    <= 1'b0;
      status_value <= 8'h00;
    end else begin
      in_reset     <= (state != ST_RUN);
      spi_ready    <= (state == ST_RUN) && next_enable[EN_SPI];
      status_value <= status[status_read_idx];
    end
  end

  // Transmit data source and receive data pins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_data      <= 1'b0;
      rx_data_pin  <= 1'b0;
      rx_clock_pin <= 1'b0;
    end else begin
      tx_data      <= next_enable[EN_PA] & (tx_from_pin ? tx_pin_data : tx_fifo_bit);
      rx_data_pin  <= rx_running & rx_data;
      rx_clock_pin <= rx_running & rx_clock;
    end
  end

  // Sources offered to the port pins
  assign pins.clk_out      = clk_ref;
  assign pins.rx_active    = rx_active_high ? rx_running : ~rx_running;
  assign pins.irq_n        = next_irq_n;
  assign pins.ant_switch   = ant_switch;
  assign pins.data         = rx_data;
  assign pins.matched_data = matched_data;
  assign pins.chip_data    = chip_data;
  assign pins.chip_strobe  = chip_strobe;
  assign pins.recv_data    = rx_data;
  assign pins.recv_strobe  = rx_clock;
  assign pins.xmit_strobe  = xmit_strobe;

  // Selects: configuration while running, reset defaults otherwise
  assign pin_sel_reset = {PIN_TRISTATE, PIN_INTERRUPT, PIN_DATA, PIN_CLK_OUT};
  assign pin_sel       = (state == ST_RUN) ? port_pin_config_two : pin_sel_reset;

  port_pin_mux #(
    .PINS (PIN_COUNT)
  ) u_pin_mux (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .src           (pins.sink),
    .pin_sel       (pin_sel),
    .pin_sel_reset (pin_sel_reset),
    .pin_out       (port_pin),
    .pin_oe_n      (port_pin_oe_n)
  );
endmodule

// ===== dv/power_reset_checker.sv
// Concurrent checks on the ports of the power and reset sequencer.
// Assumes a bind onto the sequencer top, one clock domain, sync active-low reset.
`timescale 1ns/1ps
module power_reset_checker
  import power_reset_pkg::*;
#(
  parameter int unsigned RESET_HOLD  = 8,
  parameter int unsigned PULSE_HOLD  = 3,
  parameter int unsigned TRIM_BITS   = 5,
  parameter int unsigned STATUS_REGS = 4
) (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   power_on,
  input wire logic                   brownout,
  input wire logic                   below_functional,
  input wire logic [2:0]             mode_req,
  input wire logic                   status_read,
  input wire logic [STATUS_REGS-1:0] irq_event,
  input wire logic                   trim_write,
  input wire logic                   sleep_high_precision_sel,
  input wire logic                   interrupt_out_n,
  input wire logic                   in_reset,
  input wire logic                   spi_ready,
  input wire logic [EN_WIDTH-1:0]    block_enable,
  input wire logic [TRIM_BITS-1:0]   trim_caps,
  input wire logic [7:0]             status_value
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_power_down_off: assert property (!power_on |-> ##2 block_enable == ENABLES_OFF)
    else $error("enables on while power held down");
  a_rise_starts_hold: assert property ($rose(power_on) && !brownout |-> ##[1:3]
    (in_reset && block_enable == ENABLES_DEEP_SLEEP && !interrupt_out_n)) else $error("no reset hold after power rise");
  a_exit_loads_status: assert property ($fell(in_reset) |-> !interrupt_out_n ##1 status_value == 8'hFF)
    else $error("status or interrupt wrong at reset exit");
  a_read_releases_irq: assert property (status_read && !in_reset && !interrupt_out_n && irq_event == '0
    |-> ##2 interrupt_out_n) else $error("interrupt not released by status read");
  a_brownout_holds_low: assert property ((power_on && brownout && !below_functional)[*3] |-> !interrupt_out_n)
    else $error("interrupt not low during brownout");
  a_recovery_pulse: assert property ($fell(brownout) && power_on && !below_functional
    |-> ##[1:2] interrupt_out_n ##1 interrupt_out_n) else $error("no high pulse after brownout");
  a_spi_needs_run: assert property (spi_ready |-> block_enable[EN_SPI] && !in_reset)
    else $error("spi ready outside run");
  a_pa_excludes_rx: assert property (block_enable[EN_PA] |-> !block_enable[EN_RX] && block_enable[EN_PLL])
    else $error("amplifier enable inconsistent");
  a_sleep_trim_off: assert property ((!in_reset && mode_req == MODE_SLEEP && !sleep_high_precision_sel
    && !trim_write)[*3] |-> trim_caps == '0) else $error("trim caps connected in sleep");
  c_run_entry: cover property ($fell(in_reset));
  c_status_read: cover property (status_read && !in_reset);
  c_brownout_exit: cover property ($fell(brownout));
endmodule
bind transceiver_power_reset_control power_reset_checker #(.RESET_HOLD(RESET_HOLD), .PULSE_HOLD(PULSE_HOLD),
  .TRIM_BITS(TRIM_BITS), .STATUS_REGS(STATUS_REGS)) chk (.mclk, .rst_n, .power_on, .brownout, .below_functional,
  .mode_req, .status_read, .irq_event, .trim_write, .sleep_high_precision_sel, .interrupt_out_n, .in_reset,
  .spi_ready, .block_enable, .trim_caps, .status_value);

// ===== dv/host_model.sv
// Host controller model: drives the power-on pin and status reads.
// Assumes the bench asks for actions by level on want_on and want_read.
`timescale 1ns/1ps
module host_model (
  input  wire logic mclk,
  input  wire logic interrupt_out_n,
  input  wire logic want_on,
  input  wire logic want_read,
  output logic      power_on,
  output logic      status_read
);
  // Changes land after the falling edge; a read waits for the line to be low
  always @(negedge mclk) begin
    power_on    <= want_on;
    status_read <= want_read && !interrupt_out_n;
  end
endmodule

// ===== dv/transceiver_power_reset_control_tb_top.sv
// Self-checking bench for the power and reset sequencer.
// Assumes the host model drives power-on and reads; inputs change at falling edges.
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin miscompares++; $display("unexpected %s exp %h got %h", n, e, a); end end
module transceiver_power_reset_control_tb_top;
  import power_reset_pkg::*;
  localparam int RST = 8; // Shortened reset hold
  localparam int PLS = 3; // Shortened interrupt pulse
  logic mclk = 0, rst_n = 0, want_on = 0, want_read = 0, power_on, status_read;
  logic brownout = 0, below_functional = 0, trim_write = 0, sleep_high_precision_sel = 0;
  logic xtal_startup_hp = 0, rx_active_high = 1, tx_from_pin = 0, tx_pin_data = 0, tx_fifo_bit = 0;
  logic [2:0] mode_req = 3'h1;
  logic [1:0] status_read_idx = 2'h0;
  logic [3:0] irq_event = 4'h0;
  logic [4:0] trim_wdata = 5'h00, trim_caps, t;
  logic [15:0] port_pin_config_two = 16'h0000;
  logic [7:0] src = 8'h00, block_enable, status_value;
  logic interrupt_out_n, in_reset, spi_ready, xtal_high_precision, tx_data, rx_data_pin, rx_clock_pin;
  logic [3:0] port_pin, port_pin_oe_n;
  integer miscompares = 0, tests_run = 0, seed = 32'h8429, k;
  logic [7:0] en_exp [7] = '{8'h09, 8'h1D, 8'h1F, 8'h1F, 8'h3F, 8'h7F, 8'hBF}; // Enables per mode code
  always #5 mclk = ~mclk;
  // Random pin sources
  always @(negedge mclk) src <= 8'($random(seed));
  host_model host (.mclk, .interrupt_out_n, .want_on, .want_read, .power_on, .status_read);
  transceiver_power_reset_control #(.RESET_HOLD(RST), .PULSE_HOLD(PLS)) DUT (.mclk, .rst_n, .power_on, .brownout,
    .below_functional, .mode_req, .status_read, .status_read_idx, .irq_event, .trim_write, .trim_wdata,
    .sleep_high_precision_sel, .xtal_startup_hp, .rx_active_high, .port_pin_config_two, .tx_from_pin, .tx_fifo_bit,
    .tx_pin_data, .clk_ref(src[0]), .rx_data(src[1]), .rx_clock(src[2]), .ant_switch(src[3]),
    .matched_data(src[4]), .chip_data(src[5]), .chip_strobe(src[6]), .xmit_strobe(src[7]), .interrupt_out_n,
    .in_reset, .spi_ready, .block_enable, .trim_caps, .xtal_high_precision, .status_value, .tx_data,
    .rx_data_pin, .rx_clock_pin, .port_pin, .port_pin_oe_n);
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Count cycles until the run state is reached, bounded
  task automatic wait_run();
    k = 0;
    while (in_reset !== 1'b0 && k < 40) begin cyc(1); k++; end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(16);
    `CHK("rf_pin_oe", 4'h8, port_pin_oe_n)
    rst_n <= 1; cyc(2); want_on <= 1; cyc(1); wait_run();
    `CHK("hold_len", RST + 2, k)
    `CHK("irq_low", 1'b0, interrupt_out_n)
    `CHK("spi_rdy", 1'b1, spi_ready)
    `CHK("en_sleep", en_exp[1], block_enable)
    cyc(1); `CHK("status", 8'hFF, status_value)
    want_read <= 1; cyc(1); want_read <= 0; cyc(3);
    `CHK("irq_rel", 1'b1, interrupt_out_n)
    irq_event <= 4'h1; cyc(1); irq_event <= 4'h0; cyc(1);
    `CHK("evt", 8'h01, status_value)
    $display("test power_up done");
    for (int m = 0; m < 8; m++) begin
      mode_req <= 3'(m); cyc(3);
      `CHK("mode_en", en_exp[m < 7 ? m : 6], block_enable)
      `CHK("spi_rdy", (m != 0), spi_ready)
    end
    mode_req <= MODE_TRANSMIT; tx_from_pin <= 1; tx_pin_data <= 1; cyc(3);
    `CHK("tx_pin", 1'b1, tx_data)
    tx_from_pin <= 0; tx_fifo_bit <= 1; cyc(3); `CHK("tx_fifo", 1'b1, tx_data)
    mode_req <= MODE_RECEIVE; port_pin_config_two <= {PIN_RX_ACTIVE, 12'h000}; cyc(3);
    `CHK("rx_oe", 1'b0, port_pin_oe_n[3])
    `CHK("rx_hi", 1'b1, port_pin[3])
    rx_active_high <= 0; cyc(3); `CHK("rx_lo", 1'b0, port_pin[3])
    `CHK("rx_dat", src[2:1], {rx_clock_pin, rx_data_pin})
    `CHK("tx_off", 1'b0, tx_data)
    $display("test modes done");
    t = 5'($random(seed)) | 5'h01;
    mode_req <= MODE_TX_IDLE; xtal_startup_hp <= 1; trim_wdata <= t; trim_write <= 1; cyc(1);
    trim_write <= 0; cyc(2);
    `CHK("trim", t, trim_caps)
    `CHK("xtal_hp", 1'b1, xtal_high_precision)
    mode_req <= MODE_SLEEP; cyc(3); `CHK("trim_slp", 5'h00, trim_caps)
    sleep_high_precision_sel <= 1; cyc(3); `CHK("hp_slp", 1'b1, xtal_high_precision)
    $display("test trim done");
    brownout <= 1; cyc(4);
    `CHK("bo_irq", 1'b0, interrupt_out_n)
    `CHK("bo_rst", 1'b1, in_reset)
    brownout <= 0; k = 0;
    while (interrupt_out_n !== 1'b1 && k < 5) begin cyc(1); k++; end
    k = 0;
    while (interrupt_out_n === 1'b1 && k < 10) begin cyc(1); k++; end
    `CHK("pulse", PLS, k)
    wait_run(); `CHK("bo_run", 1'b0, in_reset)
    `CHK("bo_irq2", 1'b0, interrupt_out_n)
    cyc(1); `CHK("bo_stat", 8'hFF, status_value)
    $display("test brownout done");
    want_on <= 0; cyc(3);
    `CHK("off_en", 8'h00, block_enable)
    $display("test power_down done");
    results();
  end
  // Watchdog against a hang
  initial begin
    #20000;
    miscompares++;
    results();
  end
endmodule
